// File: core/smc_mode_ctrl.sv
// Operating mode controller with send and receive buffers
//
// Behaviour
// - STOP: drivers idle, host requests get NACK
// - STOP persists until stop cause clears
// - Reassignment reinitialises driver, fault indicator lit
// - Reassignment: no traffic, buffers discarded
// - Reassignment aborts host transfers, restarts host link
// - After reassignment ready to send and receive; STOP instead while a stop cause remains
// - RUN serves host, holds received frames
// - Initialise first, then accept slot parameters
// - Parameter check before becoming ready
// - Host stop aborts host transfers, reconnects
// - Unflowed ASCII/printer finishes current send
// - ASCII keeps receiving until buffer full
// - Outside INIT, reassign only when delivered parameters differ
// - Handlers synchronise before new requests run
// - Transmit only while host runs, except to finish an unflowed ASCII/printer send
// - Report aborted send after host restart
// - Transmit only complete host frames
// - Early send requests kept until coordination
// - Deliver received frames after receive coordination
`include "smc_defines.svh"
`timescale 1ns/1ps

module smc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r, wr_ptr_nxt;
    logic [AW-1:0] rd_ptr_r, rd_ptr_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready = cnt_r != (AW+1)'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data = mem[rd_ptr_r];
    assign count = cnt_r;
    assign push = in_valid && in_ready && !flush;
    assign pop = out_valid && out_ready && !flush;

    always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        cnt_nxt = cnt_r;
        if (flush) begin
            wr_ptr_nxt = '0;
            rd_ptr_nxt = '0;
            cnt_nxt = '0;
        end else begin
            if (push) begin
                wr_ptr_nxt = wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_nxt = rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_nxt = cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_nxt = cnt_r - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end
endmodule

module smc_mode_ctrl
    import smc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic line_break_pin,
    input wire smc_host_ctl_type host_ctl,
    input wire smc_param_type param_in,
    input wire smc_word_type snd_in,
    output logic snd_ready,
    output smc_word_type rcv_out,
    input wire logic rcv_ready,
    input wire smc_word_type rx_in,
    output logic rx_ready,
    output smc_word_type tx_out,
    input wire logic tx_ready,
    output smc_mode_type mode,
    output logic group_fault_indicator,
    output logic drv_init,
    output logic host_nack,
    output logic snd_abort_err,
    output logic snd_sync_done,
    output logic rcv_sync_done
);
    function automatic logic [1:0] drv_of(input logic [15:0] w);
        drv_of = w[`SMC_PAR_DRV_MSB:`SMC_PAR_DRV_LSB];
    endfunction

    // Line break pin synchroniser
    logic lb_q1_r, lb_q2_r, lb_q3_r, lb_s_r, lb_s_nxt;

    smc_mode_type mode_r, mode_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [15:0] held_r, held_nxt;
    logic run_d_r;
    logic [2:0] ssync_r, ssync_nxt, rsync_r, rsync_nxt;
    logic wr_frame_r, wr_frame_nxt;
    logic abort_pend_r, abort_pend_nxt;
    logic flush_pend_r, flush_pend_nxt;
    logic tx_busy_r, tx_busy_nxt;
    logic [5:0] frames_r, frames_nxt;
    smc_word_type tx_r, tx_nxt, rcv_r, rcv_nxt;
    logic snd_rdy_r, snd_rdy_nxt, rx_rdy_r, rx_rdy_nxt;
    logic nack_r, nack_nxt, init_r, init_nxt, abort_r, abort_nxt;
    logic fault_r, ssync_done_r, rsync_done_r;

    logic stop_evt, start_evt, stop_cause, reassign_go;
    logic is_ascii, keep_send, flush_snd, flush_rcv;
    logic snd_push, rx_push, tx_pop, rcv_pop;
    logic sf_out_valid, rf_out_valid;
    logic [8:0] sf_out_data, rf_out_data;
    logic [5:0] sf_count, rf_count;

    smc_fifo #(.WIDTH(`SMC_WORD_W), .DEPTH(`SMC_FIFO_DEPTH)) u_snd_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .flush(flush_snd),
        .in_valid(snd_push),
        .in_data({snd_in.last, snd_in.data}),
        .in_ready(),
        .out_valid(sf_out_valid),
        .out_data(sf_out_data),
        .out_ready(tx_pop),
        .count(sf_count)
    );

    smc_fifo #(.WIDTH(`SMC_WORD_W), .DEPTH(`SMC_FIFO_DEPTH)) u_rcv_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .flush(flush_rcv),
        .in_valid(rx_push),
        .in_data({rx_in.last, rx_in.data}),
        .in_ready(),
        .out_valid(rf_out_valid),
        .out_data(rf_out_data),
        .out_ready(rcv_pop),
        .count(rf_count)
    );

    always_comb begin
        // Pin change counts once last two stages agree
        lb_s_nxt = (lb_q2_r == lb_q3_r) ? lb_q3_r : lb_s_r;

        stop_evt = run_d_r && !host_ctl.run;
        start_evt = !run_d_r && host_ctl.run;
        stop_cause = lb_s_r || (drv_of(held_r) == `SMC_DRV_NONE);
        is_ascii = drv_of(held_r) == `SMC_DRV_ASCII;
        keep_send = !held_r[`SMC_PAR_NOFLOW_BIT] ? 1'b0 :
            (is_ascii || drv_of(held_r) == `SMC_DRV_PRINTER);

        mode_nxt = mode_r;
        cnt_nxt = cnt_r;
        held_nxt = held_r;
        reassign_go = 1'b0;
        case (mode_r)
            MODE_INIT: begin
                if (cnt_r != 8'h00) begin
                    cnt_nxt = cnt_r - 8'h01;
                end else if (param_in.valid) begin
                    held_nxt = param_in.word;
                    reassign_go = 1'b1;
                end
            end
            MODE_REASSIGN: begin
                if (cnt_r != 8'h00) begin
                    cnt_nxt = cnt_r - 8'h01;
                end else begin
                    mode_nxt = stop_cause ? MODE_STOP : MODE_RUN;
                end
            end
            MODE_STOP: begin
                if (!stop_cause) begin
                    mode_nxt = MODE_RUN;
                end
            end
            MODE_RUN: begin
                if (stop_cause) begin
                    mode_nxt = MODE_STOP;
                end
            end
            default: begin
                mode_nxt = MODE_INIT;
            end
        endcase
        if ((mode_r == MODE_STOP || mode_r == MODE_RUN) && param_in.valid
                && param_in.word != held_r) begin
            held_nxt = param_in.word;
            reassign_go = 1'b1;
        end
        if (reassign_go) begin
            mode_nxt = MODE_REASSIGN;
            cnt_nxt = 8'(`SMC_REASSIGN_CYC);
        end

        // Host frame tracking and stop handling
        snd_push = snd_in.valid && snd_rdy_r && !reassign_go;
        wr_frame_nxt = wr_frame_r;
        if (snd_push) begin
            wr_frame_nxt = !snd_in.last;
        end
        abort_pend_nxt = abort_pend_r;
        abort_nxt = 1'b0;
        if (stop_evt && wr_frame_r) begin
            abort_pend_nxt = 1'b1;
        end
        if (abort_pend_r && host_ctl.run && ssync_r == `SMC_SYNC_CALLS) begin
            abort_nxt = 1'b1;
            abort_pend_nxt = 1'b0;
        end
        // Unflowed ASCII/printer frame defers the stop flush until its last word is taken
        flush_snd = reassign_go || ((flush_pend_r || stop_evt)
            && !((tx_busy_r || tx_r.valid) && keep_send));
        flush_pend_nxt = (flush_pend_r || stop_evt) && !flush_snd;
        flush_rcv = reassign_go;
        if (stop_evt || reassign_go) begin
            wr_frame_nxt = 1'b0;
        end

        // Transmit side
        tx_nxt = tx_r;
        tx_busy_nxt = tx_busy_r;
        if (tx_r.valid && tx_ready) begin
            tx_nxt.valid = 1'b0;
        end
        tx_pop = 1'b0;
        if (mode_r == MODE_RUN && sf_out_valid && (!tx_r.valid || tx_ready)) begin
            if (tx_busy_r) begin
                tx_pop = host_ctl.run || keep_send;
            end else begin
                tx_pop = host_ctl.run && ssync_r == `SMC_SYNC_CALLS
                    && frames_r != 6'h00;
            end
        end
        if (flush_snd) begin
            tx_pop = 1'b0;
        end
        if (tx_pop) begin
            tx_nxt = {1'b1, sf_out_data};
            tx_busy_nxt = !sf_out_data[8];
        end
        frames_nxt = frames_r;
        if (snd_push && snd_in.last && !(tx_pop && sf_out_data[8])) begin
            frames_nxt = frames_r + 6'h01;
        end else if (!(snd_push && snd_in.last) && tx_pop && sf_out_data[8]) begin
            frames_nxt = frames_r - 6'h01;
        end
        if (flush_snd) begin
            frames_nxt = 6'h00;
            tx_busy_nxt = 1'b0;
            tx_nxt.valid = 1'b0;
        end
        snd_rdy_nxt = mode_nxt == MODE_RUN && host_ctl.run && !flush_pend_nxt
            && sf_count < `SMC_RDY_LIMIT;

        // Receive side
        rx_push = rx_in.valid && rx_rdy_r && !reassign_go;
        rx_rdy_nxt = mode_nxt == MODE_RUN && (host_ctl.run || is_ascii)
            && rf_count < `SMC_RDY_LIMIT;
        rcv_nxt = rcv_r;
        if (rcv_r.valid && rcv_ready) begin
            rcv_nxt.valid = 1'b0;
        end
        rcv_pop = mode_r == MODE_RUN && host_ctl.run && rsync_r == `SMC_SYNC_CALLS
            && rf_out_valid && (!rcv_r.valid || rcv_ready)
            && !reassign_go;
        if (rcv_pop) begin
            rcv_nxt = {1'b1, rf_out_data};
        end
        if (reassign_go) begin
            rcv_nxt.valid = 1'b0;
        end

        // Start-up coordination with the host handlers
        ssync_nxt = ssync_r;
        rsync_nxt = rsync_r;
        if (host_ctl.snd_call && ssync_r != `SMC_SYNC_CALLS && mode_r == MODE_RUN) begin
            ssync_nxt = ssync_r + 3'h1;
        end
        if (host_ctl.rcv_call && rsync_r != `SMC_SYNC_CALLS && mode_r == MODE_RUN) begin
            rsync_nxt = rsync_r + 3'h1;
        end
        if (start_evt || stop_evt || reassign_go) begin
            ssync_nxt = 3'h0;
            rsync_nxt = 3'h0;
        end

        nack_nxt = mode_r != MODE_RUN
            && (host_ctl.snd_call || host_ctl.rcv_call);
        init_nxt = reassign_go;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lb_q1_r <= 1'b0;
            lb_q2_r <= 1'b0;
            lb_q3_r <= 1'b0;
            lb_s_r <= 1'b0;
            mode_r <= MODE_INIT;
            cnt_r <= 8'(`SMC_INIT_CYC);
            held_r <= `SMC_PAR_RESET;
            run_d_r <= 1'b0;
            ssync_r <= 3'h0;
            rsync_r <= 3'h0;
            wr_frame_r <= 1'b0;
            abort_pend_r <= 1'b0;
            flush_pend_r <= 1'b0;
            tx_busy_r <= 1'b0;
            frames_r <= 6'h00;
            tx_r <= '0;
            rcv_r <= '0;
            snd_rdy_r <= 1'b0;
            rx_rdy_r <= 1'b0;
            nack_r <= 1'b0;
            init_r <= 1'b0;
            abort_r <= 1'b0;
            fault_r <= 1'b1;
            ssync_done_r <= 1'b0;
            rsync_done_r <= 1'b0;
        end else begin
            lb_q1_r <= line_break_pin;
            lb_q2_r <= lb_q1_r;
            lb_q3_r <= lb_q2_r;
            lb_s_r <= lb_s_nxt;
            mode_r <= mode_nxt;
            cnt_r <= cnt_nxt;
            held_r <= held_nxt;
            run_d_r <= host_ctl.run;
            ssync_r <= ssync_nxt;
            rsync_r <= rsync_nxt;
            wr_frame_r <= wr_frame_nxt;
            abort_pend_r <= abort_pend_nxt;
            flush_pend_r <= flush_pend_nxt;
            tx_busy_r <= tx_busy_nxt;
            frames_r <= frames_nxt;
            tx_r <= tx_nxt;
            rcv_r <= rcv_nxt;
            snd_rdy_r <= snd_rdy_nxt;
            rx_rdy_r <= rx_rdy_nxt;
            nack_r <= nack_nxt;
            init_r <= init_nxt;
            abort_r <= abort_nxt;
            fault_r <= mode_nxt != MODE_RUN;
            ssync_done_r <= ssync_nxt == `SMC_SYNC_CALLS;
            rsync_done_r <= rsync_nxt == `SMC_SYNC_CALLS;
        end
    end

    assign mode = mode_r;
    assign group_fault_indicator = fault_r;
    assign drv_init = init_r;
    assign host_nack = nack_r;
    assign snd_abort_err = abort_r;
    assign snd_sync_done = ssync_done_r;
    assign rcv_sync_done = rsync_done_r;
    assign snd_ready = snd_rdy_r;
    assign rx_ready = rx_rdy_r;
    assign tx_out = tx_r;
    assign rcv_out = rcv_r;
endmodule

// File: inc/smc_defines.svh
// Constants for the serial link mode controller
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH

// Clock period and derived cycle counts
`define SMC_CLK_NS 20
`define SMC_INIT_NS 1000
`define SMC_INIT_CYC ((`SMC_INIT_NS + `SMC_CLK_NS - 1) / `SMC_CLK_NS)
`define SMC_REASSIGN_NS 2000
`define SMC_REASSIGN_CYC ((`SMC_REASSIGN_NS + `SMC_CLK_NS - 1) / `SMC_CLK_NS)

// Handler calls needed to finish start-up coordination
`define SMC_SYNC_CALLS 3'h2

// Buffer geometry
`define SMC_WORD_W 9
`define SMC_FIFO_DEPTH 32
`define SMC_RDY_LIMIT 6'h1e

// Parameter word fields
`define SMC_PAR_DRV_LSB 0
`define SMC_PAR_DRV_MSB 1
`define SMC_PAR_NOFLOW_BIT 2
`define SMC_DRV_NONE 2'h0
`define SMC_DRV_ASCII 2'h1
`define SMC_DRV_PRINTER 2'h2
`define SMC_PAR_RESET 16'h0000

`endif

// File: inc/smc_pkg.sv
// Types for the serial link mode controller
package smc_pkg;

    typedef enum logic [1:0] {
        MODE_INIT,
        MODE_STOP,
        MODE_REASSIGN,
        MODE_RUN
    } smc_mode_type;

    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } smc_word_type;

    typedef struct packed {
        logic run;
        logic snd_call;
        logic rcv_call;
    } smc_host_ctl_type;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } smc_param_type;

endpackage

// File: tb/smc_mode_chk.sv
// Port assertions for the mode controller
`timescale 1ns/1ps
module smc_mode_chk
    import smc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire smc_host_ctl_type host_ctl,
    input wire smc_param_type param_in,
    input wire logic rcv_ready,
    input wire logic tx_ready,
    input wire logic snd_ready,
    input wire logic rx_ready,
    input wire smc_word_type rcv_out,
    input wire smc_word_type tx_out,
    input wire smc_mode_type mode,
    input wire logic group_fault_indicator,
    input wire logic drv_init,
    input wire logic host_nack,
    input wire logic snd_sync_done,
    input wire logic rcv_sync_done
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    sequence call_refused;
        (host_ctl.snd_call || host_ctl.rcv_call) && mode != MODE_RUN;
    endsequence
    sequence tx_stalled;
        tx_out.valid && !tx_ready && host_ctl.run && mode == MODE_RUN;
    endsequence
    sequence rcv_stalled;
        rcv_out.valid && !rcv_ready && !param_in.valid && mode == MODE_RUN;
    endsequence
    fault_mode_a: assert property (group_fault_indicator == (mode != MODE_RUN))
        else $error("fault indicator disagrees with mode");
    call_nack_a: assert property (call_refused |=> host_nack)
        else $error("refused call without nack");
    reassign_quiet_a: assert property (mode == MODE_REASSIGN |-> !snd_ready && !rx_ready)
        else $error("traffic accepted during reassignment");
    drv_init_a: assert property (drv_init |-> mode == MODE_REASSIGN && $past(mode) != MODE_REASSIGN)
        else $error("driver init outside reassignment start");
    tx_run_a: assert property ($rose(tx_out.valid) |-> $past(host_ctl.run) && $past(snd_sync_done))
        else $error("transmit started without running synced host");
    rcv_sync_a: assert property ($rose(rcv_out.valid) |-> $past(rcv_sync_done))
        else $error("receive delivered before coordination");
    tx_hold_a: assert property (tx_stalled |=> tx_out.valid && $stable(tx_out.data))
        else $error("transmit word dropped while stalled");
    rcv_hold_a: assert property (rcv_stalled |=> rcv_out.valid && $stable(rcv_out))
        else $error("received word dropped before fetch");
endmodule

bind smc_mode_ctrl smc_mode_chk u_chk (.*);

// File: tb/smc_serial_peer.sv
// Serial partner: slow or prompt sink, one-word source
`timescale 1ns/1ps
module smc_serial_peer
    import smc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic stall,
    input wire logic rx_go,
    input wire logic [7:0] rx_byte,
    input wire smc_word_type tx_out,
    output logic tx_ready,
    output smc_word_type rx_in,
    input wire logic rx_ready,
    output logic [15:0] got,
    output logic [15:0] sum,
    output logic [15:0] lasts
);
    logic [1:0] phase;
    initial begin
        phase = 2'h0;
        got = 16'h0000;
        sum = 16'h0000;
        lasts = 16'h0000;
        tx_ready = 1'h1;
        rx_in = '0;
    end
    always @(posedge clk_sys) begin
        phase <= phase + 2'h1;
        tx_ready <= !stall || phase == 2'h0;
        if (tx_out.valid && tx_ready) begin
            got <= got + 16'h0001;
            sum <= sum + 16'(tx_out.data);
            lasts <= lasts + 16'(tx_out.last);
        end
        if (rx_go) begin
            rx_in <= {2'h3, rx_byte};
        end else if (rx_in.valid && rx_ready) begin
            // Released line shows inverted data
            rx_in <= {2'h0, ~rx_in.data};
        end
    end
endmodule

// File: tb/tb.sv
// Self-checking bench for the mode controller
`timescale 1ns/1ps
module tb;
    import smc_pkg::*;
    typedef struct packed {
        logic [15:0] word;
        logic brk;
        smc_mode_type want;
    } smc_row_type;
    smc_row_type rows [6] = '{
        '{16'h0001, 1'h0, MODE_RUN}, '{16'h0000, 1'h0, MODE_STOP},
        '{16'h0002, 1'h0, MODE_RUN}, '{16'h0006, 1'h1, MODE_STOP},
        '{16'h0003, 1'h0, MODE_RUN}, '{16'h0005, 1'h0, MODE_RUN}};
    logic clk_sys, rst_b = 1'h0, line_break_pin = 1'h0, rcv_ready = 1'h0;
    logic stall = 1'h0, rx_go = 1'h0, tx_ready, rx_ready, snd_ready;
    logic group_fault_indicator, drv_init, host_nack, snd_abort_err;
    logic snd_sync_done, rcv_sync_done;
    logic [7:0] rx_byte = 8'h00;
    logic [15:0] got, sum, lasts;
    smc_host_ctl_type host_ctl = '0;
    smc_param_type param_in = '0;
    smc_word_type snd_in = '0, rcv_out, rx_in, tx_out;
    smc_mode_type mode;
    int failures = 0, tests_run = 0, aborts = 0, n;
    smc_mode_ctrl dut (.*);
    smc_serial_peer peer (.*);
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want) begin
            failures++;
            $display("Error at %0t: saw %h, want %h", $time, seen, want);
        end
    endtask
    task automatic close_out;
        if (failures == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic pulse_par(input logic [15:0] w);
        @(posedge clk_sys);
        param_in <= {1'h1, w};
        @(posedge clk_sys);
        param_in.valid <= 1'h0;
        #1;
    endtask
    task automatic call(input logic rcv);
        @(posedge clk_sys);
        host_ctl.snd_call <= !rcv;
        host_ctl.rcv_call <= rcv;
        @(posedge clk_sys);
        host_ctl.snd_call <= 1'h0;
        host_ctl.rcv_call <= 1'h0;
        #1;
    endtask
    task automatic host_run(input logic r);
        @(posedge clk_sys);
        host_ctl.run <= r;
        tick(4);
    endtask
    task automatic send(input logic [7:0] b, input logic last);
        logic ok;
        @(posedge clk_sys);
        snd_in <= {1'h1, last, b};
        n = 0;
        do begin
            #1;
            ok = snd_ready;
            n++;
            @(posedge clk_sys);
        end while (ok !== 1'h1 && n < 60);
        snd_in.valid <= 1'h0;
        if (n == 60) failures++;
    endtask
    task automatic offer(input logic [7:0] b);
        @(posedge clk_sys);
        rx_byte <= b;
        rx_go <= 1'h1;
        @(posedge clk_sys);
        rx_go <= 1'h0;
    endtask
    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        #400_000;
        failures++;
        close_out;
    end
    always @(posedge clk_sys) begin
        if (snd_abort_err === 1'h1) aborts++;
    end
    initial begin
        tick(3);
        check(mode, MODE_INIT);
        check(group_fault_indicator, 1'h1);
        check(snd_ready, 1'h0);
        @(posedge clk_sys);
        rst_b <= 1'h1;
        pulse_par(16'h0001);
        check(mode, MODE_INIT);
        tick(50);
        host_run(1'h1);
        foreach (rows[k]) begin
            @(posedge clk_sys);
            line_break_pin <= rows[k].brk;
            tick(4);
            pulse_par(rows[k].word);
            check(mode, MODE_REASSIGN);
            check(drv_init, 1'h1);
            tick(99);
            check(group_fault_indicator, 1'h1);
            tick(4);
            check(mode, rows[k].want);
            call(1'h0);
            check(host_nack, rows[k].want != MODE_RUN);
        end
        pulse_par(16'h0005);
        check(drv_init, 1'h0);
        check(mode, MODE_RUN);
        host_run(1'h0);
        host_run(1'h1);
        stall <= 1'h1;
        for (int i = 0; i < 30; i++) send(8'h40 + 8'(i), i == 29);
        tick(3);
        check(snd_ready, 1'h0);
        check(tx_out.valid, 1'h0);
        call(1'h0);
        call(1'h0);
        tick(1);
        check(snd_sync_done, 1'h1);
        for (n = 0; n < 600 && got !== 16'h001e; n++) tick(1);
        check(got, 16'h001e);
        check(sum, 16'h0933);
        check(lasts, 16'h0001);
        check(snd_ready, 1'h1);
        offer(8'ha5);
        tick(6);
        check(rcv_out.valid, 1'h0);
        call(1'h1);
        call(1'h1);
        tick(4);
        check(rcv_out, {2'h3, 8'ha5});
        @(posedge clk_sys);
        rcv_ready <= 1'h1;
        @(posedge clk_sys);
        rcv_ready <= 1'h0;
        tick(2);
        check(rcv_out.valid, 1'h0);
        send(8'h11, 1'h0);
        host_run(1'h0);
        check(rx_ready, 1'h1);
        offer(8'h3c);
        host_run(1'h1);
        call(1'h0);
        call(1'h0);
        call(1'h1);
        call(1'h1);
        tick(6);
        check(16'(aborts), 16'h0001);
        check(got, 16'h001e);
        check(rcv_out, {2'h3, 8'h3c});
        // Unflowed ASCII frame mid-transmit survives a host stop
        for (int i = 0; i < 3; i++) send(8'h21 + 8'(i), i == 2);
        tick(2);
        host_run(1'h0);
        tick(40);
        check(got, 16'h0021);
        check(lasts, 16'h0002);
        check(tx_out.valid, 1'h0);
        host_run(1'h1);
        @(posedge clk_sys);
        rst_b <= 1'h0;
        tick(2);
        check(mode, MODE_INIT);
        check(rcv_out.valid, 1'h0);
        @(posedge clk_sys);
        rst_b <= 1'h1;
        tick(3);
        close_out;
    end
endmodule
